// >>> src/sas_pkg.sv
// sas_pkg: constants, timing counts and state layout of the smoke alarm sequencer.
// assumes one 10 MHz core clock; every time below but the long horn off (counted in slots) is turned into cycles at that rate.
package sas_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CORE_CLK_NS = 100;
  localparam int CYC_PER_US = 1000 / CORE_CLK_NS;
  localparam int CNT_W = 25;

  localparam int SLOW_PERIOD_US = 1670000;
  localparam int FAST_LOCAL_US = 40000;
  localparam int FAST_REMOTE_US = 41700;
  localparam int STROBE_US = 10000;
  localparam int HORN_SLOT_US = 500000;
  localparam int HORN_LONG_OFF_US = 1500000;
  localparam int IO_DELAY_US = 3000000;

  localparam logic [CNT_W-1:0] SLOW_CYC = CNT_W'(SLOW_PERIOD_US * CYC_PER_US);
  localparam logic [CNT_W-1:0] FAST_LOCAL_CYC = CNT_W'(FAST_LOCAL_US * CYC_PER_US);
  localparam logic [CNT_W-1:0] FAST_REMOTE_CYC = CNT_W'(FAST_REMOTE_US * CYC_PER_US);
  localparam logic [CNT_W-1:0] STROBE_CYC = CNT_W'(STROBE_US * CYC_PER_US);
  localparam logic [CNT_W-1:0] HORN_SLOT_CYC = CNT_W'(HORN_SLOT_US * CYC_PER_US);
  localparam logic [CNT_W-1:0] IO_DELAY_CYC = CNT_W'(IO_DELAY_US * CYC_PER_US);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  // pattern: on, off, on, off, on, then long off made of whole slots
  localparam int HORN_LONG_SLOTS = HORN_LONG_OFF_US / HORN_SLOT_US;
  localparam logic [2:0] HORN_LAST_ON_SLOT = 3'h4;
  localparam logic [2:0] HORN_LAST_SLOT = 3'(4 + HORN_LONG_SLOTS);

  localparam logic [4:0] LED_CYCLE_LAST = 5'h17;
  localparam logic [4:0] CHIRP_CYCLE = 5'h00;
  localparam logic [1:0] QUAL_TICKS = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    MODE_STANDBY = 2'b00,
    MODE_LOCAL = 2'b01,
    MODE_REMOTE_QUAL = 2'b10,
    MODE_REMOTE = 2'b11
  } sas_mode_type;

  typedef struct packed {
    logic chamber_low;
    logic battery_low;
    logic io_in;
    logic horn_input_a;
    logic timing_capacitor_pin;
  } sas_pins_type;

  typedef struct packed {
    sas_pins_type sync1;
    sas_pins_type sync2;
    sas_mode_type mode;
    logic [CNT_W-1:0] osc_cnt;
    logic [4:0] cyc_idx;
    logic [CNT_W-1:0] half_cnt;
    logic [2:0] slot;
    logic [CNT_W-1:0] io_cnt;
    logic [1:0] qual_ticks;
    logic batt_low;
    logic test_mode;
    logic horn;
    logic led;
    logic strobe;
    logic io_out;
  } sas_state_type;

  localparam sas_state_type SAS_STATE_RESET = '0;

endpackage : sas_pkg

// >>> src/sas_sequencer.sv
// sas_sequencer: strobe, alarm, horn pattern, interconnect and battery logic.
// assumes pins arrive from outside the clock domain and are synchronised here.
`timescale 1ns/1ps

module sas_sequencer #(
  parameter logic [sas_pkg::CNT_W-1:0] SLOW_CYC = sas_pkg::SLOW_CYC,
  parameter logic [sas_pkg::CNT_W-1:0] FAST_LOCAL_CYC = sas_pkg::FAST_LOCAL_CYC,
  parameter logic [sas_pkg::CNT_W-1:0] FAST_REMOTE_CYC = sas_pkg::FAST_REMOTE_CYC,
  parameter logic [sas_pkg::CNT_W-1:0] STROBE_CYC = sas_pkg::STROBE_CYC,
  parameter logic [sas_pkg::CNT_W-1:0] HORN_SLOT_CYC = sas_pkg::HORN_SLOT_CYC,
  parameter logic [sas_pkg::CNT_W-1:0] IO_DELAY_CYC = sas_pkg::IO_DELAY_CYC
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire sas_pkg::sas_pins_type pins,
  output logic horn_drive_primary,
  output logic led_drive,
  output logic sense_strobe,
  output logic io_out,
  output logic io_oe
);
  import sas_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic horn_slot_on(input logic [2:0] slot);
    horn_slot_on = (slot <= HORN_LAST_ON_SLOT) && !slot[0];
  endfunction : horn_slot_on

  function automatic logic is_alarm(input sas_mode_type mode);
    is_alarm = (mode == MODE_LOCAL) || (mode == MODE_REMOTE);
  endfunction : is_alarm

  sas_state_type st;
  sas_state_type next_st;
  logic [CNT_W-1:0] period;
  logic tick;
  logic strobe_now;
  logic sample_now;
  logic smoke;
  logic io_high;
  logic enter_alarm;
  logic chirp;

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    next_st = st;
    enter_alarm = 1'b0;
    next_st.sync1 = pins;
    next_st.sync2 = st.sync1;
    smoke = st.sync2.chamber_low;
    io_high = st.sync2.io_in;

    case (st.mode)
      MODE_LOCAL: period = FAST_LOCAL_CYC;
      MODE_REMOTE_QUAL, MODE_REMOTE: period = FAST_REMOTE_CYC;
      default: period = SLOW_CYC;
    endcase
    // switching to a shorter period mid-cycle just ends the cycle at once
    tick = st.osc_cnt >= (period - CNT_ONE);
    strobe_now = st.osc_cnt < STROBE_CYC;
    sample_now = st.osc_cnt == (STROBE_CYC - CNT_ONE);
    next_st.osc_cnt = tick ? '0 : st.osc_cnt + CNT_ONE;

    if (tick && st.mode == MODE_STANDBY)
    begin
      next_st.cyc_idx = (st.cyc_idx == LED_CYCLE_LAST) ? 5'h00 : st.cyc_idx + 5'h01;
    end

    case (st.mode)
      MODE_STANDBY:
      begin
        if (sample_now && smoke)
        begin
          next_st.mode = MODE_LOCAL;
          enter_alarm = 1'b1;
        end
        else if (io_high && !st.io_out)
        begin
          next_st.mode = MODE_REMOTE_QUAL;
          next_st.qual_ticks = 2'h0;
        end
      end
      MODE_REMOTE_QUAL:
      begin
        if (sample_now && smoke)
        begin
          next_st.mode = MODE_LOCAL;
          enter_alarm = 1'b1;
        end
        else if (!io_high)
        begin
          next_st.mode = MODE_STANDBY;
          next_st.qual_ticks = 2'h0;
        end
        else if (tick)
        begin
          if (st.qual_ticks == QUAL_TICKS)
          begin
            next_st.mode = MODE_REMOTE;
            enter_alarm = 1'b1;
          end
          else
          begin
            next_st.qual_ticks = st.qual_ticks + 2'h1;
          end
        end
      end
      MODE_REMOTE:
      begin
        if (sample_now && smoke)
        begin
          next_st.mode = MODE_LOCAL;
          enter_alarm = 1'b1;
        end
        else if (!io_high)
        begin
          next_st.mode = MODE_STANDBY;
        end
      end
      MODE_LOCAL:
      begin
        // interconnect is never read here: own drive would latch us forever
        if (sample_now && !smoke && !horn_slot_on(st.slot))
        begin
          next_st.mode = MODE_STANDBY;
        end
      end
      default: next_st.mode = MODE_STANDBY;
    endcase

    if (enter_alarm)
    begin
      next_st.half_cnt = '0;
      next_st.slot = 3'h0;
      if (st.mode != MODE_LOCAL)
      begin
        next_st.io_cnt = '0;
      end
    end
    else if (is_alarm(st.mode))
    begin
      if (st.half_cnt == HORN_SLOT_CYC - CNT_ONE)
      begin
        next_st.half_cnt = '0;
        next_st.slot = (st.slot == HORN_LAST_SLOT) ? 3'h0 : st.slot + 3'h1;
      end
      else
      begin
        next_st.half_cnt = st.half_cnt + CNT_ONE;
      end
    end

    if (st.mode == MODE_LOCAL && st.io_cnt != IO_DELAY_CYC)
    begin
      next_st.io_cnt = st.io_cnt + CNT_ONE;
    end
    next_st.io_out = (st.mode == MODE_LOCAL) && (st.io_cnt == IO_DELAY_CYC);

    // battery sampled at the end of the loaded LED pulse only
    if (st.mode == MODE_STANDBY && sample_now && st.cyc_idx == LED_CYCLE_LAST)
    begin
      next_st.batt_low = st.sync2.battery_low;
    end

    chirp = (st.mode == MODE_STANDBY) && st.batt_low && strobe_now
      && (st.cyc_idx == CHIRP_CYCLE);

    if (st.test_mode)
    begin
      next_st.horn = st.sync2.battery_low;
    end
    else
    begin
      next_st.horn = (is_alarm(st.mode) && horn_slot_on(st.slot)) || chirp;
    end

    case (st.mode)
      MODE_STANDBY: next_st.led = strobe_now && (st.cyc_idx == LED_CYCLE_LAST);
      MODE_LOCAL: next_st.led = !st.slot[0] && (st.half_cnt < STROBE_CYC);
      default: next_st.led = 1'b0;
    endcase
    next_st.strobe = strobe_now;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers; reset is synchronous and overrides the clock enable
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st <= SAS_STATE_RESET;
      st.sync1 <= pins;
      st.sync2 <= st.sync1;
      // the strap is sampled through the synchroniser while reset is held
      st.test_mode <= !st.sync2.horn_input_a && !st.sync2.timing_capacitor_pin;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  assign horn_drive_primary = st.horn;
  assign led_drive = st.led;
  assign sense_strobe = st.strobe;
  assign io_out = st.io_out;
  assign io_oe = st.io_out;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk iff clk_en);
  endclocking
  default disable iff (sys_rst);

  property p_local_period;
    (st.mode == MODE_LOCAL) |-> (period == FAST_LOCAL_CYC) && !(st.osc_cnt > FAST_LOCAL_CYC);
  endproperty
  a_local_period: assert property (p_local_period) else $error("local period wrong");

  property p_horn_pattern;
    (st.horn && !st.test_mode && $past(st.mode) != MODE_STANDBY)
      |-> horn_slot_on($past(st.slot));
  endproperty
  a_horn_pattern: assert property (p_horn_pattern) else $error("horn outside on slot");

  property p_stop_in_off;
    ($past(st.mode) == MODE_LOCAL && st.mode == MODE_STANDBY)
      |-> !horn_slot_on($past(st.slot)) && !$past(smoke);
  endproperty
  a_stop_in_off: assert property (p_stop_in_off) else $error("alarm ended badly");

  property p_no_chirp_smoke;
    ($past(st.mode) == MODE_LOCAL && !st.test_mode) |-> (st.horn == horn_slot_on($past(st.slot)));
  endproperty
  a_no_chirp_smoke: assert property (p_no_chirp_smoke) else $error("chirp in smoke");

  property p_batt_at_led;
    $changed(st.batt_low) |-> $past(st.led) && $past(st.cyc_idx) == LED_CYCLE_LAST;
  endproperty
  a_batt_at_led: assert property (p_batt_at_led) else $error("battery off LED pulse");

  property p_io_delay;
    $rose(st.io_out) |-> $past(st.io_cnt) == IO_DELAY_CYC && $past(st.mode) == MODE_LOCAL;
  endproperty
  a_io_delay: assert property (p_io_delay) else $error("interconnect early");

  property p_remote_qual;
    (st.mode == MODE_REMOTE && $past(st.mode) == MODE_REMOTE_QUAL)
      |-> $past(st.qual_ticks) == QUAL_TICKS && $past(io_high);
  endproperty
  a_remote_qual: assert property (p_remote_qual) else $error("remote qualified early");

  property p_qual_drop;
    (st.mode == MODE_REMOTE_QUAL && !io_high && !(sample_now && smoke))
      |=> st.mode == MODE_STANDBY && st.qual_ticks == 2'h0;
  endproperty
  a_qual_drop: assert property (p_qual_drop) else $error("qualification not cleared");

  property p_remote_no_led;
    ($past(st.mode) == MODE_REMOTE) |-> !st.led;
  endproperty
  a_remote_no_led: assert property (p_remote_no_led) else $error("LED in remote");

  property p_local_ignores_io;
    (st.mode == MODE_LOCAL && !(sample_now && !smoke)) |=> (st.mode == MODE_LOCAL);
  endproperty
  a_local_ignores_io: assert property (p_local_ignores_io) else $error("io read in local");

  property p_test_horn;
    (st.test_mode && $past(st.test_mode)) |-> st.horn == $past(st.sync2.battery_low);
  endproperty
  a_test_horn: assert property (p_test_horn) else $error("test horn wrong");

  property p_standby_led;
    ($past(st.mode) == MODE_STANDBY && st.led) |-> $past(st.cyc_idx) == LED_CYCLE_LAST;
  endproperty
  a_standby_led: assert property (p_standby_led) else $error("standby LED off cycle");

  c_local: cover property ($rose(st.mode == MODE_LOCAL));
  c_remote: cover property ($past(st.mode) == MODE_REMOTE_QUAL && st.mode == MODE_REMOTE);
  c_io_drive: cover property ($rose(st.io_out));
  c_chirp: cover property (st.horn && st.mode == MODE_STANDBY && !st.test_mode);

endmodule : sas_sequencer

// >>> testbench/sas_peer_model.sv
// sas_peer_model: a second detector sharing the interconnect line.
// assumes the line has a pull-down, so a released line reads low.
`timescale 1ns/1ps

module sas_peer_model #(
  parameter int DELAY = 3
) (
  input wire logic core_clk,
  input wire logic alarm_req,
  input wire logic dut_out,
  input wire logic dut_oe,
  output logic io_line
);
  int cnt = 0;
  logic drive = 1'b0;

  always @(posedge core_clk)
  begin
    // a peer drives only after its own delay; DELAY 0 answers promptly
    cnt <= alarm_req ? cnt + 1 : 0;
    drive <= alarm_req && (cnt >= DELAY);
  end

  // wired-or with pull-down: nobody driving means low
  assign io_line = drive | (dut_oe & dut_out);
endmodule : sas_peer_model

// >>> testbench/smoke_alarm_sequencer_bench.sv
// smoke_alarm_sequencer_bench: self-checking bench for sas_sequencer.
// assumes the short timing set, so every count below but DLY (in ns) is in core clock cycles.
`timescale 1ns/1ps

module smoke_alarm_sequencer_bench;
  import sas_pkg::*;
  localparam int DLY = 10;
  // short timing set stands in for clocking the capacitor pin fast
  localparam logic [CNT_W-1:0] T_SLOW = 25'h0C8;
  localparam logic [CNT_W-1:0] T_FAST_LOCAL = 25'h028;
  localparam logic [CNT_W-1:0] T_FAST_REMOTE = 25'h02A;
  // strobe stays shorter than every fast period, so sensing keeps its window
  localparam logic [CNT_W-1:0] T_STROBE = 25'h00A;
  localparam logic [CNT_W-1:0] T_SLOT = 25'h064;
  localparam logic [CNT_W-1:0] T_IO_DELAY = 25'h12C;
  typedef struct {logic smoke; logic remote; int win; logic horn; logic led; logic io;} row_type;
  row_type rows[3] = '{
    '{1'b0, 1'b0, 5000, 1'b0, 1'b1, 1'b0},
    '{1'b1, 1'b0, 1000, 1'b1, 1'b1, 1'b1},
    '{1'b0, 1'b1, 1000, 1'b1, 1'b0, 1'b0}};
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic chamber = 1'b0;
  logic batt = 1'b0;
  logic strap_a = 1'b1;
  logic strap_c = 1'b1;
  logic peer_req = 1'b0;
  logic io_line;
  logic horn, led, strobe, io_out, io_oe;
  logic h, l, o;
  sas_pins_type pins_w;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int len, gap;

  assign pins_w = {chamber, batt, io_line, strap_a, strap_c};
  always #50 core_clk = ~core_clk;

  sas_sequencer #(.SLOW_CYC(T_SLOW), .FAST_LOCAL_CYC(T_FAST_LOCAL),
    .FAST_REMOTE_CYC(T_FAST_REMOTE), .STROBE_CYC(T_STROBE), .HORN_SLOT_CYC(T_SLOT),
    .IO_DELAY_CYC(T_IO_DELAY)) i_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .pins(pins_w),
    .horn_drive_primary(horn), .led_drive(led), .sense_strobe(strobe),
    .io_out(io_out), .io_oe(io_oe));

  sas_peer_model i_peer (
    .core_clk(core_clk), .alarm_req(peer_req), .dut_out(io_out), .dut_oe(io_oe),
    .io_line(io_line));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  always @(posedge core_clk)
  begin
    cyc++;
    // generous ceiling: the whole sequence needs under 20000 cycles
    if (cyc == 60000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic check_bit(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit

  task automatic check_int(input string name, input int exp, input int got);
    n_tests++;
    if (got != exp)
    begin
      failures++;
      $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
    end
  endtask : check_int

  task automatic settle();
    @(posedge core_clk);
    #DLY;
  endtask : settle

  // watch n cycles and note whether horn, LED and interconnect drive were ever high
  task automatic run(input int n);
    h = 1'b0;
    l = 1'b0;
    o = 1'b0;
    repeat (n)
    begin
      @(negedge core_clk);
      h |= horn;
      l |= led;
      o |= io_oe & io_out;
    end
  endtask : run

  function automatic logic sig(input int w);
    return (w == 0) ? horn : (w == 1) ? led : strobe;
  endfunction : sig

  // skip a partial pulse, wait for the next rise, then count its high cycles
  task automatic high_run(input int w, input int lim, output int n);
    int t;
    t = 0;
    n = 0;
    while (sig(w) === 1'b1 && t < lim)
    begin
      @(negedge core_clk);
      t++;
    end
    while (sig(w) !== 1'b1 && t < lim)
    begin
      @(negedge core_clk);
      t++;
    end
    while (sig(w) === 1'b1 && n < lim)
    begin
      @(negedge core_clk);
      n++;
    end
  endtask : high_run

  task automatic do_reset(input logic sa, input logic sc);
    settle();
    sys_rst = 1'b1;
    strap_a = sa;
    strap_c = sc;
    // let the first reset edge pass before looking, then hold twelve edges in all
    settle();
    run(11);
    check_bit("outputs in reset", 1'b0, h | l | o | strobe);
    settle();
    sys_rst = 1'b0;
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    do_reset(1'b1, 1'b1);
    foreach (rows[i])
    begin
      settle();
      chamber = rows[i].smoke;
      peer_req = rows[i].remote;
      run(rows[i].win);
      check_bit("row horn", rows[i].horn, h);
      check_bit("row led", rows[i].led, l);
      check_bit("row io", rows[i].io, o);
      settle();
      chamber = 1'b0;
      peer_req = 1'b0;
      run(1200);
      run(300);
      check_bit("row horn stops", 1'b0, h);
    end
    high_run(2, 400, len);
    check_int("strobe width", int'(T_STROBE), len);
    gap = 0;
    while (strobe !== 1'b1 && gap < 400)
    begin
      @(negedge core_clk);
      gap++;
    end
    check_int("strobe period", int'(T_SLOW), len + gap);
    settle();
    chamber = 1'b1;
    high_run(0, 800, len);
    check_int("horn on slot", int'(T_SLOT), len);
    high_run(1, 800, len);
    check_int("alarm led width", int'(T_STROBE), len);
    settle();
    clk_en = 1'b0;
    run(300);
    check_bit("frozen io", 1'b0, o);
    settle();
    clk_en = 1'b1;
    chamber = 1'b0;
    run(1500);
    settle();
    peer_req = 1'b1;
    run(60);
    settle();
    peer_req = 1'b0;
    run(300);
    check_bit("glitch horn", 1'b0, h);
    settle();
    batt = 1'b1;
    high_run(0, 5200, len);
    check_int("chirp width", int'(T_STROBE), len);
    settle();
    batt = 1'b0;
    do_reset(1'b0, 1'b0);
    settle();
    batt = 1'b1;
    run(5);
    check_bit("test horn on", 1'b1, horn);
    settle();
    batt = 1'b0;
    run(5);
    check_bit("test horn off", 1'b0, horn);
    tally_and_finish();
  end
endmodule : smoke_alarm_sequencer_bench
